// ### flcr_pkg.sv
// shared constants and types for the flash led current configuration registers
package flcr_pkg;
  // register offsets
  localparam logic [7:0] ADDR_MONITOR = 8'h02;
  localparam logic [7:0] ADDR_FLASH1 = 8'h03;
  localparam logic [7:0] ADDR_FLASH2 = 8'h04;
  localparam logic [7:0] ADDR_TORCH1 = 8'h05;
  localparam logic [7:0] ADDR_TORCH2 = 8'h06;
  // values after reset
  localparam logic [7:0] RST_MONITOR = 8'h01;
  localparam logic [7:0] RST_CH1 = 8'hbf;
  localparam logic [7:0] RST_CH2 = 8'h3f;
  // monitor register fields
  localparam int MODE_LSB = 0;
  localparam int HYST_BIT = 2;
  localparam int LEVEL_LSB = 3;
  localparam int LOCKOUT_BIT = 6;
  // brightness register fields
  localparam int OVERRIDE_BIT = 7;
  localparam int CODE_W = 7;
  // writable bits of each register, reserved bits read zero
  localparam logic [7:0] MASK_MONITOR = 8'h7f;
  localparam logic [7:0] MASK_CH1 = 8'hff;
  localparam logic [7:0] MASK_CH2 = 8'h7f;
  localparam logic [7:0] MASK_MODE = 8'h03;
  // monitor trip level in millivolts
  localparam logic [11:0] LEVEL_BASE_MV = 12'hb54;
  localparam logic [11:0] LEVEL_STEP_MV = 12'h064;
  // serial target address
  localparam logic [6:0] TARGET_ADDR = 7'h63;
  localparam int BIT_COUNT = 8;

  typedef enum logic [1:0] {MON_OFF, MON_STOP_HOLD, MON_DOWN, MON_UP_DOWN} flcr_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR_BYTE, ST_ACK_WR, ST_RD_BYTE, ST_RD_ACK
  } flcr_state_t;
endpackage

// ### flcr_bus_if.sv
// register access signals between the serial target and the register bank
`timescale 1ns/1ps
interface flcr_bus_if;
  logic wrEn;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  modport target (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport bank (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// ### flcr_i2c_target.sv
// serial bus target: byte framing, acknowledge and register pointer
`timescale 1ns/1ps
module flcr_i2c_target #(
  parameter logic [6:0] TARGET_ADDR = flcr_pkg::TARGET_ADDR
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOe,
  flcr_bus_if.target bus
);
  logic sclQ_ff, sdaQ_ff, sclP_ff, sdaP_ff;
  logic startCond, stopCond, sclRise, sclFall;
  flcr_pkg::flcr_state_t state_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff, ptr_ff, wrAddr_ff, wrData_ff;
  logic isRead_ff, ptrPhase_ff, nack_ff, oe_ff, wrEn_ff;

  // line sampling for edge and condition detection
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sclQ_ff <= 1'b1;
      sdaQ_ff <= 1'b1;
      sclP_ff <= 1'b1;
      sdaP_ff <= 1'b1;
    end else begin
      sclQ_ff <= scl;
      sdaQ_ff <= sdaIn;
      sclP_ff <= sclQ_ff;
      sdaP_ff <= sdaQ_ff;
    end
  end

  assign startCond = sclQ_ff & sclP_ff & sdaP_ff & ~sdaQ_ff;
  assign stopCond = sclQ_ff & sclP_ff & ~sdaP_ff & sdaQ_ff;
  assign sclRise = sclQ_ff & ~sclP_ff;
  assign sclFall = ~sclQ_ff & sclP_ff;

  // byte framing; first written byte sets the pointer, later ones are data
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_ff <= flcr_pkg::ST_IDLE;
      bitCnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      wrAddr_ff <= 8'h00;
      wrData_ff <= 8'h00;
      isRead_ff <= 1'b0;
      ptrPhase_ff <= 1'b0;
      nack_ff <= 1'b0;
      oe_ff <= 1'b0;
      wrEn_ff <= 1'b0;
    end else begin
      wrEn_ff <= 1'b0;
      if (startCond) begin
        state_ff <= flcr_pkg::ST_ADDR;
        bitCnt_ff <= 4'h0;
        oe_ff <= 1'b0;
        ptrPhase_ff <= 1'b1;
      end else if (stopCond) begin
        state_ff <= flcr_pkg::ST_IDLE;
        oe_ff <= 1'b0;
      end else begin
        case (state_ff)
          flcr_pkg::ST_ADDR, flcr_pkg::ST_WR_BYTE: begin
            if (sclRise) begin
              shift_ff <= {shift_ff[6:0], sdaQ_ff};
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall && bitCnt_ff == 4'(flcr_pkg::BIT_COUNT)) begin
              if (state_ff == flcr_pkg::ST_ADDR) begin
                if (shift_ff[7:1] == TARGET_ADDR) begin
                  oe_ff <= 1'b1;
                  isRead_ff <= shift_ff[0];
                  state_ff <= flcr_pkg::ST_ACK_ADDR;
                end else begin
                  state_ff <= flcr_pkg::ST_IDLE;
                end
              end else begin
                oe_ff <= 1'b1;
                state_ff <= flcr_pkg::ST_ACK_WR;
                if (ptrPhase_ff) begin
                  ptr_ff <= shift_ff;
                  ptrPhase_ff <= 1'b0;
                end else begin
                  wrEn_ff <= 1'b1;
                  wrAddr_ff <= ptr_ff;
                  wrData_ff <= shift_ff;
                  ptr_ff <= ptr_ff + 8'h01;
                end
              end
            end
          end
          flcr_pkg::ST_ACK_ADDR: begin
            if (sclFall) begin
              bitCnt_ff <= 4'h0;
              if (isRead_ff) begin
                shift_ff <= bus.rdData;
                oe_ff <= ~bus.rdData[7];
                state_ff <= flcr_pkg::ST_RD_BYTE;
              end else begin
                oe_ff <= 1'b0;
                state_ff <= flcr_pkg::ST_WR_BYTE;
              end
            end
          end
          flcr_pkg::ST_ACK_WR: begin
            if (sclFall) begin
              oe_ff <= 1'b0;
              bitCnt_ff <= 4'h0;
              state_ff <= flcr_pkg::ST_WR_BYTE;
            end
          end
          flcr_pkg::ST_RD_BYTE: begin
            if (sclFall) begin
              if (bitCnt_ff == 4'(flcr_pkg::BIT_COUNT - 1)) begin
                oe_ff <= 1'b0;
                ptr_ff <= ptr_ff + 8'h01;
                state_ff <= flcr_pkg::ST_RD_ACK;
              end else begin
                oe_ff <= ~shift_ff[6];
                shift_ff <= {shift_ff[6:0], 1'b0};
                bitCnt_ff <= bitCnt_ff + 4'h1;
              end
            end
          end
          flcr_pkg::ST_RD_ACK: begin
            if (sclRise) begin
              nack_ff <= sdaQ_ff;
            end else if (sclFall) begin
              if (nack_ff) begin
                state_ff <= flcr_pkg::ST_IDLE;
              end else begin
                shift_ff <= bus.rdData;
                oe_ff <= ~bus.rdData[7];
                bitCnt_ff <= 4'h0;
                state_ff <= flcr_pkg::ST_RD_BYTE;
              end
            end
          end
          default: begin
            state_ff <= flcr_pkg::ST_IDLE;
            oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sdaOe = oe_ff;
  assign bus.wrEn = wrEn_ff;
  assign bus.wrAddr = wrAddr_ff;
  assign bus.wrData = wrData_ff;
  assign bus.rdAddr = ptr_ff;
endmodule

// ### flcr_regs.sv
// flash led current configuration register bank with serial access
// Function
// - two-bit monitor mode: off, hold, down, up-down
// - trip level 2.9V plus 0.1V per code
// - one bit enables undervoltage lockout, default off
// - one hysteresis bit, default zero millivolts
// - mode field frozen while torch, flash or infrared
// - seven-bit flash code, default mid code
// - seven-bit torch code, default mid code
// - reset values 0x01, 0xbf, 0x3f
`timescale 1ns/1ps
module flcr_regs #(
  parameter logic [6:0] TARGET_ADDR = flcr_pkg::TARGET_ADDR
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic deviceActive,
  output logic [1:0] monitorMode,
  output logic monitorHoldEn,
  output logic monitorDownEn,
  output logic monitorUpEn,
  output logic [2:0] monitorLevel,
  output logic [11:0] monitorTripMv,
  output logic lockoutEn,
  output logic monitorHyst,
  output logic [6:0] flashCode1,
  output logic [6:0] flashCode2,
  output logic [6:0] torchCode1,
  output logic [6:0] torchCode2
);
  logic rstS1_ff, rstN_ff;
  logic [7:0] monitor_ff, flash1_ff, flash2_ff, torch1_ff, torch2_ff;
  logic [1:0] modeLatch_ff;
  logic holdEn_ff, downEn_ff, upEn_ff, sdaOut_ff;
  logic [11:0] tripMv_ff;
  logic [6:0] flash2Eff_ff, torch2Eff_ff;
  logic [4:0] selWr;

  flcr_bus_if bus ();

  if (TARGET_ADDR == 7'h00) begin : g_addr_check
    $error("target address zero is the general call address");
  end

  // one-hot register select, used for writes and reads
  function automatic logic [4:0] regSel(input logic [7:0] addr);
    regSel = 5'h00;
    case (addr)
      flcr_pkg::ADDR_MONITOR: regSel = 5'h01;
      flcr_pkg::ADDR_FLASH1: regSel = 5'h02;
      flcr_pkg::ADDR_FLASH2: regSel = 5'h04;
      flcr_pkg::ADDR_TORCH1: regSel = 5'h08;
      flcr_pkg::ADDR_TORCH2: regSel = 5'h10;
      default: regSel = 5'h00;
    endcase
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstS1_ff <= 1'b0;
      rstN_ff <= 1'b0;
    end else begin
      rstS1_ff <= 1'b1;
      rstN_ff <= rstS1_ff;
    end
  end

  flcr_i2c_target #(.TARGET_ADDR(TARGET_ADDR)) u_target (
    .clk(clk),
    .rstN(rstN_ff),
    .scl(scl),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .bus(bus.target)
  );

  assign selWr = bus.wrEn ? regSel(bus.wrAddr) : 5'h00;

  // monitor register; mode bits ignore writes while the device runs
  always_ff @(posedge clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      monitor_ff <= flcr_pkg::RST_MONITOR;
    end else if (selWr[0]) begin
      monitor_ff[7:2] <= bus.wrData[7:2] & flcr_pkg::MASK_MONITOR[7:2];
      if (!deviceActive) begin
        monitor_ff[1:0] <= bus.wrData[1:0];
      end
    end
  end

  // brightness registers; reserved bit of channel two stays zero
  always_ff @(posedge clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      flash1_ff <= flcr_pkg::RST_CH1;
      flash2_ff <= flcr_pkg::RST_CH2;
      torch1_ff <= flcr_pkg::RST_CH1;
      torch2_ff <= flcr_pkg::RST_CH2;
    end else begin
      if (selWr[1]) begin
        flash1_ff <= bus.wrData & flcr_pkg::MASK_CH1;
      end
      if (selWr[2]) begin
        flash2_ff <= bus.wrData & flcr_pkg::MASK_CH2;
      end
      if (selWr[3]) begin
        torch1_ff <= bus.wrData & flcr_pkg::MASK_CH1;
      end
      if (selWr[4]) begin
        torch2_ff <= bus.wrData & flcr_pkg::MASK_CH2;
      end
    end
  end

  // mode in use is latched while torch, flash or infrared runs
  always_ff @(posedge clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      modeLatch_ff <= flcr_pkg::RST_MONITOR[1:0];
      holdEn_ff <= 1'b0;
      downEn_ff <= 1'b0;
      upEn_ff <= 1'b0;
    end else if (!deviceActive) begin
      modeLatch_ff <= monitor_ff[1:0];
      holdEn_ff <= flcr_pkg::flcr_mode_t'(monitor_ff[1:0]) == flcr_pkg::MON_STOP_HOLD;
      downEn_ff <= flcr_pkg::flcr_mode_t'(monitor_ff[1:0]) == flcr_pkg::MON_DOWN ||
                   flcr_pkg::flcr_mode_t'(monitor_ff[1:0]) == flcr_pkg::MON_UP_DOWN;
      upEn_ff <= flcr_pkg::flcr_mode_t'(monitor_ff[1:0]) == flcr_pkg::MON_UP_DOWN;
    end
  end

  // trip level and channel two follow logic
  always_ff @(posedge clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      tripMv_ff <= flcr_pkg::LEVEL_BASE_MV;
      flash2Eff_ff <= flcr_pkg::RST_CH1[6:0];
      torch2Eff_ff <= flcr_pkg::RST_CH1[6:0];
      sdaOut_ff <= 1'b0;
    end else begin
      tripMv_ff <= flcr_pkg::LEVEL_BASE_MV +
                   12'(monitor_ff[5:3] * flcr_pkg::LEVEL_STEP_MV);
      flash2Eff_ff <= flash1_ff[7] ? flash1_ff[6:0] : flash2_ff[6:0];
      torch2Eff_ff <= torch1_ff[7] ? torch1_ff[6:0] : torch2_ff[6:0];
      sdaOut_ff <= 1'b0;
    end
  end

  // read data; unmapped offsets read zero
  always_comb begin
    case (regSel(bus.rdAddr))
      5'h01: bus.rdData = monitor_ff;
      5'h02: bus.rdData = flash1_ff;
      5'h04: bus.rdData = flash2_ff;
      5'h08: bus.rdData = torch1_ff;
      5'h10: bus.rdData = torch2_ff;
      default: bus.rdData = 8'h00;
    endcase
  end

  assign sdaOut = sdaOut_ff;
  assign monitorMode = modeLatch_ff;
  assign monitorHoldEn = holdEn_ff;
  assign monitorDownEn = downEn_ff;
  assign monitorUpEn = upEn_ff;
  assign monitorLevel = monitor_ff[5:3];
  assign monitorTripMv = tripMv_ff;
  assign lockoutEn = monitor_ff[flcr_pkg::LOCKOUT_BIT];
  assign monitorHyst = monitor_ff[flcr_pkg::HYST_BIT];
  assign flashCode1 = flash1_ff[6:0];
  assign flashCode2 = flash2Eff_ff;
  assign torchCode1 = torch1_ff[6:0];
  assign torchCode2 = torch2Eff_ff;

  // checks
  logic firstCyc_ff;
  always_ff @(posedge clk or negedge rstN_ff) begin
    if (!rstN_ff) begin
      firstCyc_ff <= 1'b1;
    end else begin
      firstCyc_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstN_ff);

  a_reset_values: assert property (firstCyc_ff |-> monitor_ff == 8'h01 && flash1_ff == 8'hbf && flash2_ff == 8'h3f && torch1_ff == 8'hbf && torch2_ff == 8'h3f)
    else $error("register values after reset are wrong");
  a_mode_write_held: assert property (deviceActive |=> monitor_ff[1:0] == $past(monitor_ff[1:0]))
    else $error("mode field changed while device active");
  a_mode_out_frozen: assert property (deviceActive ##1 deviceActive |-> $stable(monitorMode))
    else $error("mode in use changed while device active");
  a_mode_write_taken: assert property (selWr[0] && !deviceActive |=> monitor_ff[1:0] == $past(bus.wrData[1:0]))
    else $error("mode write not taken while idle");
  a_mode_decode: assert property (!deviceActive ##1 monitor_ff[1:0] == 2'h3 && !deviceActive |=> monitorUpEn && monitorDownEn && !monitorHoldEn)
    else $error("up and down mode decoded wrongly");
  a_level_trip: assert property (selWr[0] |=> ##1 monitorTripMv == 12'd2900 + 12'd100 * 12'($past(bus.wrData[5:3], 2)))
    else $error("trip level does not follow level code");
  a_lockout_hyst: assert property (selWr[0] |=> lockoutEn == $past(bus.wrData[6]) && monitorHyst == $past(bus.wrData[2]) && !monitor_ff[7])
    else $error("lockout or hysteresis bit not stored");
  a_flash_code: assert property (selWr[1] |=> flashCode1 == $past(bus.wrData[6:0]))
    else $error("flash code not stored");
  a_torch_code: assert property (selWr[4] |=> torch2_ff == {1'b0, $past(bus.wrData[6:0])})
    else $error("torch code not stored or reserved bit set");
  a_follow_flash: assert property (##1 flashCode2 == ($past(flash1_ff[7]) ? $past(flash1_ff[6:0]) : $past(flash2_ff[6:0])))
    else $error("channel two flash code does not follow override");
  a_follow_torch: assert property (torch1_ff[7] ##1 torch1_ff[7] && $stable(torch1_ff) |-> torchCode2 == torch1_ff[6:0])
    else $error("channel two torch code does not follow channel one");
  a_decode_off: assert property (monitorMode == 2'h0 |-> !monitorHoldEn && !monitorDownEn && !monitorUpEn)
    else $error("disabled mode still enables the monitor");
  a_decode_hold: assert property (monitorMode == 2'h1 && !firstCyc_ff |-> monitorHoldEn && !monitorDownEn && !monitorUpEn)
    else $error("stop and hold mode decoded wrongly");

  c_blocked_write: cover property (selWr[0] && deviceActive);
  c_override_off: cover property (selWr[1] && !bus.wrData[7]);
  c_read_monitor: cover property (regSel(bus.rdAddr) == 5'h01 && sdaOe);
endmodule

// ### flcr_host_model.sv
// serial bus host model driving the register bank from the far side
`timescale 1ns/1ps
module flcr_host_model (
  input wire logic clk,
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves only while scl is low
  task automatic bit_io(input logic b, output logic s);
    tick(1);
    sdaLow <= ~b;
    tick(5);
    scl <= 1'b1;
    tick(5);
    s = sda;
    scl <= 1'b0;
  endtask
  // start and repeated start
  task automatic start();
    tick(1);
    sdaLow <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sdaLow <= 1'b1;
    tick(5);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sdaLow <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(5);
    sdaLow <= 1'b0;
    tick(5);
  endtask
  // msb first, then the ninth bit
  task automatic byte_io(input logic [7:0] d, input logic ackOut,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ackOut, ack);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [7:0] d[$], output logic ok);
    logic [7:0] q;
    logic a;
    start();
    byte_io({dev, 1'b0}, 1'b1, q, a);
    ok = ~a;
    byte_io(ptr, 1'b1, q, a);
    ok = ok & ~a;
    foreach (d[i]) begin
      byte_io(d[i], 1'b1, q, a);
      ok = ok & ~a;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n,
                    output logic [7:0] q[$], output logic ok);
    logic [7:0] b;
    logic a;
    q = {};
    start();
    byte_io({flcr_pkg::TARGET_ADDR, 1'b0}, 1'b1, b, a);
    ok = ~a;
    byte_io(ptr, 1'b1, b, a);
    ok = ok & ~a;
    start();
    byte_io({flcr_pkg::TARGET_ADDR, 1'b1}, 1'b1, b, a);
    ok = ok & ~a;
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, i == n - 1, b, a);
      q.push_back(b);
    end
    stop();
  endtask
endmodule

// ### tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); n_errors++; end end
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic deviceActive = 1'b0;
  wire scl, sdaLow, sdaOut, sdaOe, monitorHoldEn, monitorDownEn, monitorUpEn;
  wire lockoutEn, monitorHyst;
  wire [1:0] monitorMode;
  wire [2:0] monitorLevel;
  wire [11:0] monitorTripMv;
  wire [6:0] flashCode1, flashCode2, torchCode1, torchCode2;
  wire sda = ~(sdaLow | sdaOe);
  int n_errors = 0;
  int compares = 0;
  int m[8];
  int v;
  logic ok;
  logic [7:0] q[$];
  always #10 clk = ~clk;
  flcr_regs flcr_regs_i (.clk(clk), .rst_b(rst_b), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .deviceActive(deviceActive),
    .monitorMode(monitorMode), .monitorHoldEn(monitorHoldEn),
    .monitorDownEn(monitorDownEn), .monitorUpEn(monitorUpEn),
    .monitorLevel(monitorLevel), .monitorTripMv(monitorTripMv),
    .lockoutEn(lockoutEn), .monitorHyst(monitorHyst), .flashCode1(flashCode1),
    .flashCode2(flashCode2), .torchCode1(torchCode1), .torchCode2(torchCode2));
  flcr_host_model flcr_host_model_i (.clk(clk), .scl(scl), .sdaLow(sdaLow), .sda(sda));
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // model write, reserved bits cleared
  task automatic mw(input int a, input int x);
    if (a == 2) m[2] = deviceActive ? ((x & 'h7c) | (m[2] & 'h03)) : (x & 'h7f);
    else if (a == 3 || a == 5) m[a] = x & 'hff;
    else if (a == 4 || a == 6) m[a] = x & 'h7f;
  endtask
  task automatic put(input int a, input logic [7:0] d[$]);
    logic k;
    flcr_host_model_i.wr(flcr_pkg::TARGET_ADDR, 8'(a), d, k);
    `CHK("write ack", 1, k)
    foreach (d[i]) mw(a + i, d[i]);
  endtask
  task automatic check_all();
    logic [7:0] r[$];
    logic k;
    int md;
    int l;
    flcr_host_model_i.rd(8'h02, 5, r, k);
    `CHK("read ack", 1, k)
    `CHK("sda out", 0, sdaOut)
    for (int i = 0; i < 5; i++) `CHK("readback", m[i + 2], r[i])
    md = m[2] & 3;
    l = (m[2] >> 3) & 7;
    `CHK("mode", md, monitorMode)
    `CHK("hold", md == 1, monitorHoldEn)
    `CHK("down", md >> 1, monitorDownEn)
    `CHK("up", md == 3, monitorUpEn)
    `CHK("level", l, monitorLevel)
    `CHK("trip", 2900 + 100 * l, monitorTripMv)
    `CHK("lockout", (m[2] >> 6) & 1, lockoutEn)
    `CHK("hyst", (m[2] >> 2) & 1, monitorHyst)
    `CHK("flash1", m[3] & 'h7f, flashCode1)
    `CHK("torch1", m[5] & 'h7f, torchCode1)
    `CHK("flash2", m[m[3] >> 7 ? 3 : 4] & 'h7f, flashCode2)
    `CHK("torch2", m[m[5] >> 7 ? 5 : 6] & 'h7f, torchCode2)
  endtask
  initial begin
    void'($urandom(23));
    m = '{0, 0, 'h01, 'hbf, 'h3f, 'hbf, 'h3f, 0};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    check_all();
    // every level code and every mode
    for (int i = 0; i < 8; i++) begin
      v = ($urandom & 'hc4) | (i << 3) | (i % 4);
      put(2, '{8'(v)});
      check_all();
    end
    put(2, '{8'h09});
    deviceActive <= 1'b1;
    put(2, '{8'h6b});
    check_all();
    deviceActive <= 1'b0;
    put(2, '{8'h6b});
    check_all();
    // bursts with override set and cleared, boundary codes
    for (int k = 0; k < 2; k++) begin
      put(3, '{k ? 8'h80 : 8'h7f, 8'($urandom), 8'({k[0], 7'($urandom)}), 8'($urandom)});
      check_all();
    end
    // reset in mid-run brings every register back to its default
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    m = '{0, 0, 'h01, 'hbf, 'h3f, 'hbf, 'h3f, 0};
    repeat (5) @(posedge clk);
    check_all();
    put(7, '{8'($urandom)});
    foreach (m[i]) if (i == 1 || i == 7) begin
      flcr_host_model_i.rd(8'(i), 1, q, ok);
      `CHK("unmapped", 0, q[0])
    end
    flcr_host_model_i.wr(7'h22, 8'h03, '{8'h00}, ok);
    `CHK("foreign ack", 0, ok)
    check_all();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule
